// ### tb/psram_sync_burst_port_bench.sv
// self-checking bench joining the host controller and the device end
`timescale 1ns/1ns
`default_nettype none
`include "psram_consts.svh"
module psram_sync_burst_port_bench;
    import psram_pkg::*;
    logic clock;
    logic rst_n;
    logic devRstN;
    logic ce;
    reg_addr_t regAddr;
    reg_data_t regWrData;
    logic regWrStb;
    logic regRdStb;
    reg_data_t regRdData;
    waddr_t peekAddr;
    word_t peekData;
    logic earlyStrobe;
    logic burstActive;
    logic burstIsWrite;
    int errCount;
    int nTests;
    int cycles = 0;
    reg_data_t rdVal;
    word_t oldW[4];
    word_t newW[4];
    word_t expW[4];
    psram_link_if link();
    psram_host_end u_psram_host_end (.clock(clock), .rst_n(rst_n), .ce(ce),
        .regAddr(regAddr), .regWrData(regWrData), .regWrStb(regWrStb),
        .regRdStb(regRdStb), .regRdData(regRdData), .link(link));
    psram_device_end u_psram_device_end (.link(link), .rst_n(devRstN),
        .peekAddr(peekAddr), .peekData(peekData), .burstActive(burstActive),
        .burstIsWrite(burstIsWrite), .earlyStrobe(earlyStrobe));
    psram_sync_burst_port_chk u_chk (.linkClk(link.linkClk), .rst_n(devRstN),
        .csN(link.csN), .addressValidN(link.addressValidN), .weN(link.weN),
        .oeN(link.oeN), .modeRegSetN(link.modeRegSetN), .devDq(link.devDq),
        .devDqOeN(link.devDqOeN), .devWaitOeN(link.devWaitOeN), .waitN(link.waitN));
    initial clock = 1'b0;
    always #50 clock = ~clock;
    task automatic endSim();
        if (errCount == 0 && nTests > 0)
            $display("All tests passed");
        else
            $display("Some tests failed");
        $finish;
    endtask
    task automatic check(input reg_data_t got, input reg_data_t exp);
        nTests++;
        if (got !== exp)
        begin
            errCount++;
            $display("ERROR %0t: got %h expected %h", $time, got, exp);
        end
    endtask
    task automatic wr(input reg_addr_t a, input reg_data_t d);
        @(posedge clock);
        regAddr <= a;
        regWrData <= d;
        regWrStb <= 1'b1;
        @(posedge clock);
        regWrStb <= 1'b0;
    endtask
    task automatic rd(input reg_addr_t a, output reg_data_t d);
        @(posedge clock);
        regAddr <= a;
        regRdStb <= 1'b1;
        @(posedge clock);
        regRdStb <= 1'b0;
        #1;
        d = regRdData;
    endtask
    task automatic loadWords(input logic useNew);
        for (int i = 0; i < 4; i++)
            wr(`REG_WDATA + 8'(4 * i), {16'h0, useNew ? newW[i] : oldW[i]});
    endtask
    // start a burst and wait for the controller to go idle
    task automatic burst(input waddr_t a, input reg_data_t ctrl);
        int i;
        i = 0;
        wr(`REG_ADDR, {24'h0, a});
        wr(`REG_CTRL, ctrl);
        rd(`REG_STATUS, rdVal);
        check(rdVal & 32'h1, 32'h1);
        while (rdVal[0] !== 1'b0 && i < 100)
        begin
            rd(`REG_STATUS, rdVal);
            i++;
        end
        check(rdVal, 32'h0);
    endtask
    task automatic cmpRead();
        for (int i = 0; i < 4; i++)
        begin
            rd(`REG_RDATA + 8'(4 * i), rdVal);
            check(rdVal, {16'h0, expW[i]});
        end
    endtask
    always @(posedge clock)
    begin
        cycles <= cycles + 1;
        if (cycles == 20000)
        begin
            errCount++;
            endSim();
        end
    end
    initial
    begin
        rst_n = 1'b0;
        devRstN = 1'b0;
        ce = 1'b1;
        regAddr = 8'h00;
        regWrData = 32'h0;
        regWrStb = 1'b0;
        regRdStb = 1'b0;
        peekAddr = 8'h00;
        errCount = 0;
        nTests = 0;
        for (int i = 0; i < 4; i++)
        begin
            oldW[i] = 16'hA0B0 + 16'h0101 * 16'(i);
            newW[i] = 16'h1C2D + 16'h1111 * 16'(i);
        end
        repeat (4) @(posedge clock);
        rst_n <= 1'b1;
        repeat (8) @(posedge clock);
        devRstN <= 1'b1;
        rd(`REG_STATUS, rdVal);
        check(rdVal, 32'h0);
        rd(8'h30, rdVal);
        check(rdVal, 32'h0);
        loadWords(1'b0);
        wr(`REG_MASK, 32'h0);
        burst(8'h10, 32'h3);
        // beat 1 lower lane and beat 2 both lanes masked
        loadWords(1'b1);
        wr(`REG_MASK, 32'h34);
        burst(8'h10, 32'h3);
        burst(8'h10, 32'h1);
        expW = newW;
        expW[1] = {newW[1][15:8], oldW[1][7:0]};
        expW[2] = oldW[2];
        cmpRead();
        @(posedge clock);
        peekAddr <= 8'h12;
        repeat (4) @(posedge clock);
        check({16'h0, peekData}, {16'h0, oldW[2]});
        // select held low, addresses wrap past the top
        wr(`REG_MASK, 32'h0);
        burst(8'hFE, 32'h7);
        check({30'h0, burstActive, burstIsWrite}, 32'h1);
        burst(8'hFE, 32'h5);
        check({30'h0, burstActive, burstIsWrite}, 32'h0);
        expW = newW;
        cmpRead();
        wr(`REG_CTRL, 32'h0);
        check({31'h0, earlyStrobe}, 32'h0);
        endSim();
    end
endmodule
`default_nettype wire

// ### tb/psram_sync_burst_port_chk.sv
// assertions on the pins between the pSRAM device end and its host
`timescale 1ns/1ns
`default_nettype none
module psram_sync_burst_port_chk
(
    input wire logic linkClk,
    input wire logic rst_n,
    input wire logic csN,
    input wire logic addressValidN,
    input wire logic weN,
    input wire logic oeN,
    input wire logic modeRegSetN,
    input wire psram_pkg::word_t devDq,
    input wire logic devDqOeN,
    input wire logic devWaitOeN,
    input wire logic waitN
);
    import psram_pkg::*;
    logic [3:0] cnt_reg;
    logic [3:0] cnt_next;
    logic taken_reg;
    wire startEdge = !csN && !addressValidN && !taken_reg && modeRegSetN;
    wire counting = cnt_reg != 4'h0 && cnt_reg != 4'hF;
    // link rises since the burst start, saturating
    assign cnt_next = csN ? 4'h0 : (startEdge ? 4'h1 : (counting ? cnt_reg + 4'h1 : cnt_reg));
    always_ff @(posedge linkClk)
    begin
        cnt_reg <= rst_n ? cnt_next : 4'h0;
        taken_reg <= rst_n && !csN && !addressValidN;
    end
    default clocking cb @(posedge linkClk);
    endclocking
    default disable iff (!rst_n);
    a_wait_low: assert property (!csN && cnt_reg inside {[1:3]} |-> !waitN)
        else $error("wait not low during latency");
    a_wait_ready: assert property (!csN && cnt_reg inside {[4:8]} |-> waitN)
        else $error("wait not high after latency minus one");
    a_wait_float: assert property (csN |-> devWaitOeN && waitN)
        else $error("wait driven while deselected");
    a_strobe_once: assert property (cnt_reg == 4'h2 |-> addressValidN)
        else $error("strobe low over more than one rise");
    a_read_first: assert property (startEdge && weN && !oeN |-> ##5 !devDqOeN)
        else $error("read data not driven after latency");
    a_no_overlap: assert property (startEdge |-> cnt_reg == 4'h0 || cnt_reg >= 4'h9)
        else $error("burst started before previous end");
    a_mode_off: assert property (!csN |-> modeRegSetN)
        else $error("mode set active during burst");
    a_last_hold: assert property (!startEdge && !csN && !oeN && weN && cnt_reg >= 4'h9
        && $past(cnt_reg) >= 4'h9 |-> !devDqOeN && $stable(devDq))
        else $error("last read word not held");
    c_read: cover property (startEdge && weN);
    c_write: cover property (startEdge && !weN);
    c_held: cover property (startEdge && !$past(csN));
endmodule
`default_nettype wire

// ### verilog/psram_consts.svh
// constants of the burst pSRAM link, device end and host controller
`ifndef PSRAM_CONSTS_SVH
`define PSRAM_CONSTS_SVH
`define ADDR_W 8
`define DATA_W 16
`define BYTE_W 8
`define WORDS 256
`define CNT_W 4
`define LAT 4'h5
`define BURST_LEN 4'h4
`define CLK_NS 100
`define GAP_NS 7
`define GAP_CYC ((`GAP_NS + `CLK_NS - 1) / `CLK_NS)
`define BC_MAX_NS 2500
`define BC_MAX_CYC (`BC_MAX_NS / `CLK_NS)
`define REG_AW 8
`define REG_DW 32
`define REG_ADDR 8'h00
`define REG_CTRL 8'h04
`define REG_STATUS 8'h08
`define REG_MASK 8'h0C
`define REG_WDATA 8'h10
`define REG_RDATA 8'h20
`define BLK_MSB 7
`define BLK_LSB 4
`define IDX_MSB 3
`define IDX_LSB 2
`define CTRL_GO 0
`define CTRL_WRITE 1
`define CTRL_HOLD 2
`define STAT_BUSY 0
`define STAT_OVERRUN 1
`define MASK_W 8
`define LANES 2
`endif

// ### verilog/psram_device_end.sv
// device end of the burst pSRAM link: latency, wait output and burst data
`timescale 1ns/1ns
`default_nettype none
`include "psram_consts.svh"

module psram_device_end
(
    psram_link_if.device link,
    input wire logic rst_n,
    input wire psram_pkg::waddr_t peekAddr,
    output psram_pkg::word_t peekData,
    output logic burstActive,
    output logic burstIsWrite,
    output logic earlyStrobe
);
    import psram_pkg::*;

    logic advTaken_reg;
    logic active_reg;
    logic isWrite_reg;
    logic ready_reg;
    logic dataValid_reg;
    logic earlyStrobe_reg;
    cnt_t edgeCnt_reg;
    waddr_t base_reg;
    word_t rdOut_reg;
    word_t peek_reg;
    cnt_t edgeCnt_next;
    waddr_t curAddr;
    word_t curWord;
    word_t peekWord;
    logic selected;
    logic strobeFresh;
    logic startEdge;
    logic beatEdge;
    logic writeBeat;
    logic readBeat;
    logic lastBeat;

    // edge counts that carry a data beat
    function automatic logic inBeats(cnt_t c);
        return (c >= `LAT - 4'h1) && (c <= `LAT + `BURST_LEN - 4'h2);
    endfunction

    function automatic waddr_t beatAddr(waddr_t b, cnt_t c);
        return b + waddr_t'(c - (`LAT - 4'h1));
    endfunction

    assign selected = !link.csN;
    assign strobeFresh = !link.addressValidN && !advTaken_reg;
    assign startEdge = selected && strobeFresh && link.modeRegSetN;
    assign beatEdge = selected && active_reg && !startEdge && inBeats(edgeCnt_reg);
    assign writeBeat = beatEdge && isWrite_reg;
    assign readBeat = beatEdge && !isWrite_reg;
    assign lastBeat = edgeCnt_reg == `LAT + `BURST_LEN - 4'h2;
    assign edgeCnt_next = startEdge ? 4'h1 : edgeCnt_reg + 4'h1;
    assign curAddr = beatAddr(base_reg, edgeCnt_reg);

    psram_word_store store (
        .clk(link.linkClk),
        .wrEn(writeBeat),
        .wrAddr(curAddr),
        .wrData(link.dq),
        .laneEnN({link.upperByteN, link.lowerByteN}),
        .rdAddrA(curAddr),
        .rdDataA(curWord),
        .rdAddrB(peekAddr),
        .rdDataB(peekWord)
    );

    // strobe seen since it last went high
    always_ff @(posedge link.linkClk)
    begin
        if (!rst_n || link.csN)
            advTaken_reg <= 1'b0;
        else if (!link.addressValidN)
            advTaken_reg <= 1'b1;
        else
            advTaken_reg <= 1'b0;
    end

    // burst sequencing
    always_ff @(posedge link.linkClk)
    begin
        if (!rst_n || link.csN)
        begin
            active_reg <= 1'b0;
            edgeCnt_reg <= 4'h0;
            isWrite_reg <= 1'b0;
            base_reg <= {`ADDR_W{1'b0}};
        end
        else if (startEdge)
        begin
            active_reg <= 1'b1;
            edgeCnt_reg <= edgeCnt_next;
            isWrite_reg <= !link.weN;
            base_reg <= link.addr;
        end
        else if (active_reg)
        begin
            edgeCnt_reg <= edgeCnt_next;
            if (lastBeat)
                active_reg <= 1'b0;
        end
    end

    always_ff @(posedge link.linkClk)
    begin
        if (!rst_n)
            earlyStrobe_reg <= 1'b0;
        else if (startEdge && active_reg)
            earlyStrobe_reg <= 1'b1;
    end

    // wait level
    always_ff @(posedge link.linkClk)
    begin
        if (!rst_n || link.csN)
            ready_reg <= 1'b0;
        else if (startEdge)
            ready_reg <= edgeCnt_next >= `LAT - 4'h1;
        else if (active_reg && edgeCnt_next == `LAT - 4'h1)
            ready_reg <= 1'b1;
    end

    // read data
    always_ff @(posedge link.linkClk)
    begin
        if (!rst_n || link.csN)
        begin
            dataValid_reg <= 1'b0;
            rdOut_reg <= {`DATA_W{1'b0}};
        end
        else if (startEdge)
            dataValid_reg <= 1'b0;
        // last word stays after the burst
        else if (readBeat)
        begin
            rdOut_reg <= curWord;
            dataValid_reg <= 1'b1;
        end
    end

    always_ff @(posedge link.linkClk)
    begin
        if (!rst_n)
            peek_reg <= {`DATA_W{1'b0}};
        else
            peek_reg <= peekWord;
    end

    // fresh strobe pulls wait low at once
    assign link.devWait = ready_reg && !strobeFresh;
    assign link.devWaitOeN = link.csN;
    assign link.devDqOeN = !(selected && !link.oeN && !isWrite_reg && dataValid_reg);
    assign link.devDq = rdOut_reg;
    assign peekData = peek_reg;
    assign burstActive = active_reg;
    assign burstIsWrite = isWrite_reg;
    assign earlyStrobe = earlyStrobe_reg;
endmodule
`default_nettype wire

// ### verilog/psram_host_end.sv
// host controller end of the burst pSRAM link, driving the link clock
//
// The plain strobed port and the address map are this design's own decisions.
`timescale 1ns/1ns
`default_nettype none
`include "psram_consts.svh"

module psram_host_end
(
    input wire logic clock,
    input wire logic rst_n,
    input wire logic ce,
    input wire psram_pkg::reg_addr_t regAddr,
    input wire psram_pkg::reg_data_t regWrData,
    input wire logic regWrStb,
    input wire logic regRdStb,
    output psram_pkg::reg_data_t regRdData,
    psram_link_if.host link
);
    import psram_pkg::*;

    host_state_t state_reg;
    cnt_t n_reg;
    logic [7:0] bc_reg;
    logic [3:0] gap_reg;
    logic pend_reg;
    logic overrun_reg;
    waddr_t addr_reg;
    logic write_reg;
    logic hold_reg;
    logic [`MASK_W-1:0] mask_reg;
    word_t wdata_reg [`BURST_LEN];
    word_t rdata_reg [`BURST_LEN];
    word_t dqS1_reg;
    word_t dqS2_reg;
    logic linkClk_reg;
    logic csN_reg;
    logic advN_reg;
    logic weN_reg;
    logic oeN_reg;
    logic ubN_reg;
    logic lbN_reg;
    waddr_t addrOut_reg;
    word_t dqOut_reg;
    logic dqOeN_reg;
    reg_data_t rdMux;
    logic tick;
    logic busy;
    logic go;
    cnt_t nn;
    cnt_t endN;
    logic wrWin;
    logic rdWin;
    logic tooLong;
    logic done;
    logic [1:0] beatW;
    logic [1:0] beatR;
    logic [`LANES-1:0] laneMask;

    function automatic logic blockHit(reg_addr_t a, reg_addr_t base);
        return a[`BLK_MSB:`BLK_LSB] == base[`BLK_MSB:`BLK_LSB];
    endfunction

    function automatic logic [1:0] beatIdx(cnt_t c, cnt_t first);
        return 2'(c - first);
    endfunction

    // falling link edge: outputs change half a period before device samples
    assign tick = ce && linkClk_reg;
    assign busy = pend_reg || state_reg != H_IDLE;
    assign go = ce && regWrStb && regAddr == `REG_CTRL && regWrData[`CTRL_GO] && !busy;
    assign nn = n_reg + 4'h1;
    // latency and length fix the beat windows
    assign wrWin = write_reg && nn >= `LAT - 4'h1 && nn <= `LAT + `BURST_LEN - 4'h2;
    assign rdWin = !write_reg && nn >= `LAT + 4'h1 && nn <= `LAT + `BURST_LEN;
    assign endN = write_reg ? `LAT + `BURST_LEN - 4'h1 : `LAT + `BURST_LEN;
    // cut a burst at the cycle-time limit
    assign tooLong = bc_reg >= 8'(`BC_MAX_CYC);
    assign done = nn == endN || tooLong;
    assign beatW = beatIdx(nn, `LAT - 4'h1);
    assign beatR = beatIdx(nn, `LAT + 4'h1);
    assign laneMask = `LANES'(mask_reg >> {beatW, 1'b0});

    always_comb
    begin
        rdMux = '0;
        if (regAddr == `REG_ADDR)
            rdMux = reg_data_t'(addr_reg);
        else if (regAddr == `REG_CTRL)
            rdMux = reg_data_t'({hold_reg, write_reg, 1'b0});
        else if (regAddr == `REG_STATUS)
            rdMux = reg_data_t'({overrun_reg, busy});
        else if (regAddr == `REG_MASK)
            rdMux = reg_data_t'(mask_reg);
        else if (blockHit(regAddr, `REG_WDATA))
            rdMux = reg_data_t'(wdata_reg[regAddr[`IDX_MSB:`IDX_LSB]]);
        else if (blockHit(regAddr, `REG_RDATA))
            rdMux = reg_data_t'(rdata_reg[regAddr[`IDX_MSB:`IDX_LSB]]);
    end

    always_ff @(posedge clock)
    begin
        if (!rst_n)
            regRdData <= '0;
        else if (ce && regRdStb)
            regRdData <= rdMux;
    end

    // setup writes are ignored while a burst is pending or running
    always_ff @(posedge clock)
    begin
        if (!rst_n)
        begin
            addr_reg <= {`ADDR_W{1'b0}};
            write_reg <= 1'b0;
            hold_reg <= 1'b0;
            mask_reg <= {`MASK_W{1'b0}};
            for (int i = 0; i < `BURST_LEN; i++)
                wdata_reg[i] <= {`DATA_W{1'b0}};
        end
        else if (ce && regWrStb && !busy)
        begin
            if (regAddr == `REG_ADDR)
                addr_reg <= regWrData[`ADDR_W-1:0];
            else if (regAddr == `REG_CTRL)
            begin
                write_reg <= regWrData[`CTRL_WRITE];
                hold_reg <= regWrData[`CTRL_HOLD];
            end
            else if (regAddr == `REG_MASK)
                mask_reg <= regWrData[`MASK_W-1:0];
            else if (blockHit(regAddr, `REG_WDATA))
                wdata_reg[regAddr[`IDX_MSB:`IDX_LSB]] <= regWrData[`DATA_W-1:0];
        end
    end

    // link clock divider and read-data synchroniser
    always_ff @(posedge clock)
    begin
        if (!rst_n)
        begin
            linkClk_reg <= 1'b0;
            dqS1_reg <= {`DATA_W{1'b0}};
            dqS2_reg <= {`DATA_W{1'b0}};
        end
        else if (ce)
        begin
            linkClk_reg <= !linkClk_reg;
            dqS1_reg <= link.dq;
            dqS2_reg <= dqS1_reg;
        end
    end

    always_ff @(posedge clock)
    begin
        if (!rst_n)
        begin
            state_reg <= H_IDLE;
            n_reg <= 4'h0;
            bc_reg <= 8'h00;
            gap_reg <= 4'h0;
            pend_reg <= 1'b0;
            overrun_reg <= 1'b0;
            csN_reg <= 1'b1;
            advN_reg <= 1'b1;
            weN_reg <= 1'b1;
            oeN_reg <= 1'b1;
            ubN_reg <= 1'b1;
            lbN_reg <= 1'b1;
            addrOut_reg <= {`ADDR_W{1'b0}};
            dqOut_reg <= {`DATA_W{1'b0}};
            dqOeN_reg <= 1'b1;
            for (int i = 0; i < `BURST_LEN; i++)
                rdata_reg[i] <= {`DATA_W{1'b0}};
        end
        else if (ce)
        begin
            if (go)
                pend_reg <= 1'b1;
            case (state_reg)
                H_IDLE:
                begin
                    bc_reg <= 8'h00;
                    gap_reg <= 4'h0;
                    // held select: fresh strobe and address
                    if (tick && pend_reg)
                    begin
                        pend_reg <= 1'b0;
                        n_reg <= 4'h0;
                        csN_reg <= 1'b0;
                        advN_reg <= 1'b0;
                        addrOut_reg <= addr_reg;
                        weN_reg <= !write_reg;
                        oeN_reg <= write_reg;
                        ubN_reg <= 1'b0;
                        lbN_reg <= 1'b0;
                        state_reg <= H_BURST;
                    end
                    else if (tick && !hold_reg)
                    begin
                        csN_reg <= 1'b1;
                        oeN_reg <= 1'b1;
                    end
                end
                H_BURST:
                begin
                    bc_reg <= bc_reg + 8'h01;
                    if (tick)
                    begin
                        n_reg <= nn;
                        advN_reg <= 1'b1;
                        weN_reg <= 1'b1;
                        dqOeN_reg <= !wrWin;
                        dqOut_reg <= wdata_reg[beatW];
                        {ubN_reg, lbN_reg} <= wrWin ? laneMask : 2'h0;
                        if (rdWin)
                            rdata_reg[beatR] <= dqS2_reg;
                        if (done)
                        begin
                            csN_reg <= !hold_reg;
                            // held select keeps the last read word enabled
                            oeN_reg <= oeN_reg || !hold_reg;
                            dqOeN_reg <= 1'b1;
                            ubN_reg <= 1'b1;
                            lbN_reg <= 1'b1;
                            overrun_reg <= overrun_reg || tooLong;
                            state_reg <= H_GAP;
                        end
                    end
                end
                H_GAP:
                begin
                    gap_reg <= gap_reg + 4'h1;
                    if (gap_reg >= 4'(`GAP_CYC - 1))
                        state_reg <= H_IDLE;
                end
                default:
                    state_reg <= H_IDLE;
            endcase
        end
    end

    assign link.linkClk = linkClk_reg;
    assign link.csN = csN_reg;
    assign link.addressValidN = advN_reg;
    assign link.weN = weN_reg;
    assign link.oeN = oeN_reg;
    assign link.upperByteN = ubN_reg;
    assign link.lowerByteN = lbN_reg;
    assign link.modeRegSetN = 1'b1;
    assign link.addr = addrOut_reg;
    assign link.hostDq = dqOut_reg;
    assign link.hostDqOeN = dqOeN_reg;
endmodule
`default_nettype wire

// ### verilog/psram_link_if.sv
// pins between the burst pSRAM device end and its host controller
`timescale 1ns/1ns
`default_nettype none
`include "psram_consts.svh"
interface psram_link_if;
    import psram_pkg::*;
    logic linkClk;
    logic csN;
    logic addressValidN;
    logic weN;
    logic oeN;
    logic upperByteN;
    logic lowerByteN;
    logic modeRegSetN;
    waddr_t addr;
    word_t hostDq;
    logic hostDqOeN;
    word_t devDq;
    logic devDqOeN;
    logic devWait;
    logic devWaitOeN;
    word_t dq;
    logic waitN;
    // wire levels from the enables, pulled high when nobody drives
    assign dq = !hostDqOeN ? hostDq : (!devDqOeN ? devDq : {`DATA_W{1'b1}});
    assign waitN = !devWaitOeN ? devWait : 1'b1;
    modport device (
        input linkClk, csN, addressValidN, weN, oeN, upperByteN, lowerByteN,
        input modeRegSetN, addr, dq,
        output devDq, devDqOeN, devWait, devWaitOeN
    );
    modport host (
        output linkClk, csN, addressValidN, weN, oeN, upperByteN, lowerByteN,
        output modeRegSetN, addr, hostDq, hostDqOeN,
        input dq, waitN
    );
endinterface
`default_nettype wire

// ### verilog/psram_pkg.sv
// types shared by the burst pSRAM link ends
`include "psram_consts.svh"
package psram_pkg;
    typedef logic [`ADDR_W-1:0] waddr_t;
    typedef logic [`DATA_W-1:0] word_t;
    typedef logic [`CNT_W-1:0] cnt_t;
    typedef logic [`REG_AW-1:0] reg_addr_t;
    typedef logic [`REG_DW-1:0] reg_data_t;
    typedef enum {H_IDLE, H_BURST, H_GAP} host_state_t;
endpackage

// ### verilog/psram_word_store.sv
// word array of the pSRAM die with per-lane write masking
`timescale 1ns/1ns
`default_nettype none
`include "psram_consts.svh"
module psram_word_store
(
    input wire logic clk,
    input wire logic wrEn,
    input wire psram_pkg::waddr_t wrAddr,
    input wire psram_pkg::word_t wrData,
    input wire logic [`LANES-1:0] laneEnN,
    input wire psram_pkg::waddr_t rdAddrA,
    output psram_pkg::word_t rdDataA,
    input wire psram_pkg::waddr_t rdAddrB,
    output psram_pkg::word_t rdDataB
);
    import psram_pkg::*;
    word_t mem [`WORDS];

    always_ff @(posedge clk)
    begin
        if (wrEn && !laneEnN[0])
            mem[wrAddr][`BYTE_W-1:0] <= wrData[`BYTE_W-1:0];
        if (wrEn && !laneEnN[1])
            mem[wrAddr][`DATA_W-1:`BYTE_W] <= wrData[`DATA_W-1:`BYTE_W];
    end

    assign rdDataA = mem[rdAddrA];
    assign rdDataB = mem[rdAddrB];
endmodule
`default_nettype wire
